// [logic/lcm_muting.sv]
/*
 Light curtain muting logic: forward, bidirectional and position muting with override.
 Assumes inputs arrive asynchronously from pins and are resynchronised here.
*/
module lcm_muting #(
   parameter int unsigned SCAN_CYCLES_P = lcm_pkg::SCAN_CYCLES,
   parameter int unsigned SYNC_SCANS_P  = lcm_pkg::SYNC_SCANS
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // Configuration
   input  wire lcm_pkg::lcm_mode_t   mode,
   // Field inputs, active high
   input  wire lcm_pkg::lcm_sensors_t sensors,
   input  wire logic                 light_curtain_input,
   input  wire logic                 override_input,
   // Status
   output lcm_pkg::lcm_status_t      status
);
   timeunit 1ns;
   timeprecision 1ps;
   import lcm_pkg::*;

   typedef enum logic [2:0] {
      LCM_IDLE, LCM_ENT_WAIT, LCM_EXT_WAIT, LCM_MUTE_ENT, LCM_MUTE_EXT, LCM_OVERRIDE, LCM_LOCKED
   } lcm_state_t;

   // ==========================================
   // Input synchronisers
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_q <= 6'h00;
         sync_q <= 6'h00;
      end else begin
         meta_q <= {sensors, light_curtain_input, override_input};
         sync_q <= meta_q;
      end
   end

   // ==========================================
   // Scan strobe
   logic [SCAN_CNT_W-1:0] scan_cnt_q;
   logic                  scan_tick;
   assign scan_tick = (scan_cnt_q == SCAN_CNT_W'(SCAN_CYCLES_P - 1));
   always_ff @(posedge clk) begin
      if (!rstn) begin
         scan_cnt_q <= SCAN_RESET;
      end else if (scan_tick) begin
         scan_cnt_q <= SCAN_RESET;
      end else begin
         scan_cnt_q <= scan_cnt_q + 1'b1;
      end
   end

   // ==========================================
   // Per-scan input image
   lcm_sensors_t img_q;
   lcm_sensors_t prv_q;
   logic         curtain_q;
   logic         ovr_q;
   logic         ovr_prv_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         img_q     <= '0;
         prv_q     <= '0;
         curtain_q <= 1'b0;
         ovr_q     <= 1'b0;
         ovr_prv_q <= 1'b0;
      end else if (scan_tick) begin
         img_q     <= sync_q[5:2];
         prv_q     <= img_q;
         curtain_q <= sync_q[1];
         ovr_q     <= sync_q[0];
         ovr_prv_q <= ovr_q;
      end
   end

   // Evaluation runs one clock after the image is taken
   logic eval_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         eval_q <= 1'b0;
      end else begin
         eval_q <= scan_tick;
      end
   end

   function automatic logic rise(input logic now, input logic prv);
      return now & ~prv;
   endfunction

   logic e1_r, e2_r, x2_r, ovr_r;
   logic any_on;
   assign e1_r   = rise(img_q.entry_sensor_first, prv_q.entry_sensor_first);
   assign e2_r   = rise(img_q.entry_sensor_second, prv_q.entry_sensor_second);
   assign x2_r   = rise(img_q.exit_sensor_second, prv_q.exit_sensor_second);
   assign ovr_r  = rise(ovr_q, ovr_prv_q);
   assign any_on = |img_q;

   // ==========================================
   // Sequencer
   lcm_state_t            state_q;
   logic [SYNC_CNT_W-1:0] sync_cnt_q;
   logic                  sync_err_q;
   logic                  seq_err_q;
   logic                  bidir;
   logic                  sync_over;
   assign bidir     = (mode == LCM_MODE_BIDIR);
   assign sync_over = (sync_cnt_q >= SYNC_CNT_W'(SYNC_SCANS_P));

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync_cnt_q <= SYNC_RESET;
      end else if (eval_q) begin
         if (state_q == LCM_ENT_WAIT || state_q == LCM_EXT_WAIT) begin
            if (!sync_over) begin
               sync_cnt_q <= sync_cnt_q + 1'b1;
            end
         end else begin
            sync_cnt_q <= SYNC_RESET;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q    <= LCM_IDLE;
         sync_err_q <= 1'b0;
         seq_err_q  <= 1'b0;
      end else if (eval_q) begin
         if (ovr_r && img_q.entry_sensor_second && state_q != LCM_LOCKED) begin
            state_q <= LCM_OVERRIDE;
         end else begin
            case (state_q)
               LCM_IDLE: begin
                  if (mode == LCM_MODE_POSITION) begin
                     if (img_q.entry_sensor_first) begin
                        state_q <= LCM_MUTE_ENT;
                     end
                  end else if (e1_r && e2_r) begin
                     seq_err_q <= 1'b1;
                     state_q   <= LCM_LOCKED;
                  end else if (e2_r && !img_q.entry_sensor_first) begin
                     seq_err_q <= 1'b1;
                     state_q   <= LCM_LOCKED;
                  end else if (e1_r) begin
                     state_q <= LCM_ENT_WAIT;
                  end else if (bidir && x2_r && !img_q.exit_sensor_first) begin
                     state_q <= LCM_EXT_WAIT;
                  end
               end
               LCM_ENT_WAIT: begin
                  if (!img_q.entry_sensor_first) begin
                     state_q <= LCM_IDLE;
                  end else if (img_q.entry_sensor_second) begin
                     if (sync_over) begin
                        sync_err_q <= 1'b1;
                        state_q    <= LCM_IDLE;
                     end else begin
                        sync_err_q <= 1'b0;
                        state_q    <= LCM_MUTE_ENT;
                     end
                  end
               end
               LCM_EXT_WAIT: begin
                  if (!img_q.exit_sensor_second) begin
                     state_q <= LCM_IDLE;
                  end else if (img_q.exit_sensor_first) begin
                     if (sync_over) begin
                        sync_err_q <= 1'b1;
                        state_q    <= LCM_IDLE;
                     end else begin
                        sync_err_q <= 1'b0;
                        state_q    <= LCM_MUTE_EXT;
                     end
                  end
               end
               LCM_MUTE_ENT: begin
                  if (mode == LCM_MODE_POSITION) begin
                     if (!img_q.entry_sensor_first) begin
                        state_q <= LCM_IDLE;
                     end
                  end else if (prv_q.exit_sensor_first && !img_q.exit_sensor_first) begin
                     state_q <= LCM_IDLE;
                  end
               end
               LCM_MUTE_EXT: begin
                  if (prv_q.entry_sensor_second && !img_q.entry_sensor_second) begin
                     state_q <= LCM_IDLE;
                  end
               end
               LCM_OVERRIDE: begin
                  if (!img_q.entry_sensor_second || !ovr_q) begin
                     state_q <= any_on ? LCM_LOCKED : LCM_IDLE;
                  end
               end
               LCM_LOCKED: begin
                  if (!any_on && !seq_err_q) begin
                     state_q <= LCM_IDLE;
                  end
               end
               default: state_q <= LCM_IDLE;
            endcase
         end
      end
   end

   // ==========================================
   // Outputs, updated at scan end
   logic muting;
   assign muting = (state_q == LCM_MUTE_ENT) || (state_q == LCM_MUTE_EXT) || (state_q == LCM_OVERRIDE);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         status <= '0;
      end else if (eval_q) begin
         status.muting_status   <= muting;
         status.override_status <= (state_q == LCM_OVERRIDE);
         status.sync_error      <= sync_err_q;
         status.sequence_error  <= seq_err_q;
         status.fault_present   <= (sync_err_q || seq_err_q) && !curtain_q && !muting;
         status.output_permit   <= muting || (curtain_q && !(status.fault_present));
      end
   end
endmodule

// [logic/lcm_pkg.sv]
/*
 Constants, modes and carrier structs for the light curtain muting block.
 Assumes a single 100 MHz clock and a scan strobe made inside the block.
*/
// Behaviour
// - With no muting input active and the curtain clear, the output permit stays on.
// - Forward mode: entry first then entry second active, in order, enables muting and sets the muting flag.
// - While muting is on, the permit stays on even with the curtain obstructed.
// - Forward mode: exit first going inactive ends muting and clears the muting flag.
// - Bidirectional mode: exit second then exit first active, in order, also enables muting.
// - Bidirectional mode: muting ends when exit first clears on entrance travel or entry second clears on exit travel.
// - The delay between the two inputs of a pair is bounded by a settable sync time, 3 s by default.
// - Position mode: entry first alone active enables muting at once.
// - Position mode: entry first going inactive ends muting.
// - Override active starts override, sets the override flag and forces muting and the permit on; the code needs its rising edge with entry second active.
// - Forced muting ends, clearing both flags, once entry second no longer sees the workpiece.
// - Entry second before entry first, or both together, raises a sequence error.
// - A sync error clears itself when a valid sequence next enables muting.
// - Curtain obstructed while a sync or sequence error stands drops the permit and raises the fault; the code does neither while muting is on.
package lcm_pkg;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Timing
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned SCAN_TIME_US   = 1000;
   localparam int unsigned SCAN_CYCLES    = SCAN_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SYNC_TIME_MS   = 3000;
   localparam int unsigned SYNC_SCANS     = (SYNC_TIME_MS * 1000) / SCAN_TIME_US;
   localparam int unsigned SCAN_CNT_W     = 20;
   localparam int unsigned SYNC_CNT_W     = 16;
   localparam logic [SYNC_CNT_W-1:0] SYNC_RESET = 16'h0000;
   localparam logic [SCAN_CNT_W-1:0] SCAN_RESET = 20'h00000;

   // ==========================================
   // Modes
   typedef enum logic [1:0] {
      LCM_MODE_FORWARD,
      LCM_MODE_BIDIR,
      LCM_MODE_POSITION
   } lcm_mode_t;

   // ==========================================
   // Carriers
   typedef struct packed {
      logic entry_sensor_first;
      logic entry_sensor_second;
      logic exit_sensor_first;
      logic exit_sensor_second;
   } lcm_sensors_t;

   typedef struct packed {
      logic output_permit;
      logic muting_status;
      logic override_status;
      logic sync_error;
      logic sequence_error;
      logic fault_present;
   } lcm_status_t;
endpackage

// [verif/lcm_monitor.sv]
/*
 Checker for the muting block status port.
 Assumes binding to lcm_muting with short scans.
*/
module lcm_monitor #(
   parameter int unsigned SCAN_CYCLES_P = 10,
   parameter int unsigned SYNC_SCANS_P  = 5
) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rstn,
   // Watched ports
   input wire lcm_pkg::lcm_mode_t    mode,
   input wire lcm_pkg::lcm_sensors_t sensors,
   input wire logic                  light_curtain_input,
   input wire logic                  override_input,
   input wire lcm_pkg::lcm_status_t  status
);
   timeunit 1ns;
   timeprecision 1ps;
   import lcm_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // Quiet time counter
   localparam int LIM = 2 * SCAN_CYCLES_P + 6;
   logic [7:0] quiet_q;
   always_ff @(posedge clk) begin
      if (!rstn || sensors != 4'h0 || !light_curtain_input || override_input || status[2:0] != 3'h0)
         quiet_q <= 8'h00;
      else if (quiet_q != 8'hFF)
         quiet_q <= quiet_q + 8'h01;
   end
   property p_quiet; quiet_q > LIM |-> status.output_permit; endproperty
   property p_sync_clr; $fell(status.sync_error) |-> status.muting_status; endproperty
   property p_seq; status.sequence_error |=> status.sequence_error; endproperty
   property p_ovr; status.override_status |-> status.muting_status; endproperty
   property p_mute;
      status.muting_status && !status.fault_present && !$past(status.fault_present) |-> status.output_permit;
   endproperty
   property p_fault; $rose(status.fault_present) |-> ##[0:LIM] !status.output_permit; endproperty
   property p_stand; $changed(status) |=> $stable(status) [*8]; endproperty
   property p_ovr_end;
      status.override_status && $fell(sensors.entry_sensor_second) |-> ##[1:LIM] !status.override_status;
   endproperty
   property p_pos;
      mode == LCM_MODE_POSITION && !override_input && $fell(sensors.entry_sensor_first)
         |-> ##[1:LIM] !status.muting_status;
   endproperty
   a_quiet: assert property (p_quiet) else $error("permit low while quiet");
   a_seq: assert property (p_seq) else $error("sequence error dropped");
   a_ovr: assert property (p_ovr) else $error("override without muting");
   a_mute: assert property (p_mute) else $error("permit low while muting");
   a_fault: assert property (p_fault) else $error("permit kept under fault");
   a_stand: assert property (p_stand) else $error("status changed within scan");
   a_ovr_end: assert property (p_ovr_end) else $error("override kept");
   a_pos: assert property (p_pos) else $error("position muting kept");
   a_sync_clr: assert property (p_sync_clr) else $error("sync error cleared without muting");
   c_mute: cover property (status.muting_status && !light_curtain_input);
   c_ovr: cover property (status.override_status);
   c_fault: cover property (status.fault_present);
endmodule
bind lcm_muting lcm_monitor #(.SCAN_CYCLES_P(SCAN_CYCLES_P), .SYNC_SCANS_P(SYNC_SCANS_P)) i_mon (
   .clk(clk), .rstn(rstn), .mode(mode), .sensors(sensors),
   .light_curtain_input(light_curtain_input), .override_input(override_input), .status(status));

// [verif/lcm_field_model.sv]
/*
 Field side model: muting sensors, limit switch pair, light curtain.
 Assumes the bench sets the requested levels.
*/
module lcm_field_model (
   // Requested levels
   input wire lcm_pkg::lcm_sensors_t req,
   input wire logic                  lim_no,
   input wire logic                  lim_nc,
   input wire logic                  clear,
   // Field side
   output lcm_pkg::lcm_sensors_t     sensors,
   output logic                      light_curtain_input
);
   timeunit 1ns;
   timeprecision 1ps;
   import lcm_pkg::*;
   // Entry first also set by the complementary switch pair
   always_comb begin
      sensors = req;
      sensors.entry_sensor_first = req.entry_sensor_first | (lim_no & ~lim_nc);
   end
   assign light_curtain_input = clear;
endmodule

// [verif/light_curtain_muting_logic_bench.sv]
/*
 Testbench for lcm_muting.
 Assumes the field model and the bound checker.
*/
module light_curtain_muting_logic_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import lcm_pkg::*;
   localparam int SC = 10;
   localparam int SY = 5;
   logic clk = 0, rstn = 0, ovr = 0, lno = 0, lnc = 1, clr = 1, lci;
   lcm_mode_t mode = LCM_MODE_FORWARD;
   lcm_sensors_t req = 4'h0, sens;
   lcm_status_t st;
   int num_errors = 0, checks = 0;
   always #5 clk = ~clk;
   lcm_field_model i_fld (.req(req), .lim_no(lno), .lim_nc(lnc), .clear(clr),
      .sensors(sens), .light_curtain_input(lci));
   lcm_muting #(.SCAN_CYCLES_P(SC), .SYNC_SCANS_P(SY)) i_dut (.clk(clk), .rstn(rstn), .mode(mode),
      .sensors(sens), .light_curtain_input(lci), .override_input(ovr), .status(st));
   // ==========================================
   // Helpers
   task finish_test;
      if (num_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(string n, logic e, logic g);
      checks++;
      if (e !== g) begin
         num_errors++;
         $display("unexpected %s: expected %b seen %b", n, e, g);
      end
   endtask
   task scans(int n); repeat (n * SC) @(negedge clk); endtask
   task set(lcm_sensors_t s); @(negedge clk) req = s; scans(3); endtask
   task reset;
      int i;
      @(negedge clk) rstn = 0;
      repeat (20) @(negedge clk);
      rstn = 1;
      for (i = 0; i < 5 * SC && st.output_permit !== 1'b1; i++) @(negedge clk);
      chk("permit", 1'b1, st.output_permit);
      if (i == 5 * SC) finish_test;
   endtask
   // ==========================================
   // Scenarios
   task t_forward;
      set(4'h8);
      set(4'hC);
      chk("mute", 1'b1, st.muting_status);
      clr = 0;
      scans(3);
      chk("permit", 1'b1, st.output_permit);
      clr = 1;
      set(4'hE);
      set(4'h2);
      chk("mute", 1'b1, st.muting_status);
      set(4'h0);
      chk("mute", 1'b0, st.muting_status);
   endtask
   task t_bidir;
      mode = LCM_MODE_BIDIR;
      set(4'h1);
      set(4'h3);
      chk("mute", 1'b1, st.muting_status);
      set(4'h7);
      set(4'h4);
      chk("mute", 1'b1, st.muting_status);
      set(4'h0);
      chk("mute", 1'b0, st.muting_status);
   endtask
   task t_position;
      mode = LCM_MODE_POSITION;
      lno = 1;
      scans(3);
      chk("mute", 1'b0, st.muting_status);
      lnc = 0;
      scans(3);
      chk("mute", 1'b1, st.muting_status);
      lno = 0;
      lnc = 1;
      scans(3);
      chk("mute", 1'b0, st.muting_status);
      mode = LCM_MODE_FORWARD;
   endtask
   task t_sync_override;
      set(4'h8);
      scans(SY + 2);
      set(4'hC);
      chk("sync", 1'b1, st.sync_error);
      chk("mute", 1'b0, st.muting_status);
      clr = 0;
      scans(3);
      chk("fault", 1'b1, st.fault_present);
      chk("permit", 1'b0, st.output_permit);
      ovr = 1;
      scans(3);
      chk("ovr", 1'b1, st.override_status);
      chk("mute", 1'b1, st.muting_status);
      chk("permit", 1'b1, st.output_permit);
      set(4'h8);
      chk("ovr", 1'b0, st.override_status);
      chk("mute", 1'b0, st.muting_status);
      ovr = 0;
      clr = 1;
      set(4'h0);
      set(4'h8);
      set(4'hC);
      chk("sync", 1'b0, st.sync_error);
      set(4'h2);
      set(4'h0);
   endtask
   task t_sequence;
      set(4'h4);
      set(4'h0);
      chk("seq", 1'b1, st.sequence_error);
      reset;
      set(4'hC);
      chk("seq", 1'b1, st.sequence_error);
   endtask
   initial begin
      reset;
      t_forward;
      t_bidir;
      t_position;
      t_sync_override;
      t_sequence;
      finish_test;
   end
endmodule
